// >>> hdl/irap_pkg.sv
`default_nettype none
package irap_pkg;
  localparam logic [6:0] TARGET_ADDR_LOW = 7'h4C;
  localparam logic [6:0] TARGET_ADDR_HIGH = 7'h4D;
  localparam int PTR_W = 16;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CRC_FLAG_BIT = 7;
  localparam int RW_BIT = 0;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [15:0] MSG_BASE_DEF = 16'h0100;
  localparam logic [15:0] MSG_SIZE_DEF = 16'h000A;
  localparam logic [15:0] CRC_BYTE_COUNT = 16'h0001;

  typedef enum logic [1:0] {
    IRAP_IDX_LOW,
    IRAP_IDX_HIGH,
    IRAP_IDX_DATA
  } irap_idx_t;

  // Nine states need four bits
  typedef enum logic [3:0] {
    IRAP_IDLE,
    IRAP_ADDR,
    IRAP_WR_BYTE,
    IRAP_ACK,
    IRAP_RD_REQ,
    IRAP_RD_WAIT,
    IRAP_RD_LOAD,
    IRAP_RD_BYTE,
    IRAP_RD_ACK
  } irap_state_t;
endpackage
`default_nettype wire

// >>> hdl/irap_sync.sv
`default_nettype none
module irap_sync #(
  parameter logic RST_VAL = 1'h1
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Pin and filtered level
  input wire logic pin,
  output var logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once two stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      level <= s2_reg;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/irap_crc8.sv
`default_nettype none
module irap_crc8 #(
  parameter logic [7:0] POLY = irap_pkg::CRC_POLY
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Control and data
  input wire logic clear,
  input wire logic feed,
  input wire logic [7:0] data,
  output var logic [7:0] crc
);
  function automatic logic [7:0] irap_crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ POLY) : (r << 1);
    end
    return r;
  endfunction

  // Clear and feed together start a fresh sum with this byte
  always_ff @(posedge clk) begin
    if (srst) begin
      crc <= irap_pkg::CRC_INIT;
    end else if (feed) begin
      crc <= irap_crc_step(clear ? irap_pkg::CRC_INIT : crc, data);
    end else if (clear) begin
      crc <= irap_pkg::CRC_INIT;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/irap_target.sv
// Operation
// - Own address sampled from strap after reset: low gives 0x4C, high 0x4D.
// - First byte after START holds address in bits 7..1, direction in bit 0.
// - Write: two bytes after address load the pointer, low byte then high.
// - Each write data byte stored at pointer, pointer then advances by one.
// - STOP after a write restores pointer to that write's start location.
// - High address top bit set selects checksum; last byte is checksum, not data.
// - Checksum covers both pointer bytes and every data byte of the write, not the address byte.
// - Data is still stored when the checksum mismatches.
// - Host NACK on a read returns pointer to that read's start location.
// - Pointer stays valid across reads, no rewrite needed for ordered reads.
// - Reads in the message object rewind pointer after each message.
// - Change line asserts whenever a new packet is pending for the host and the interface is selected.
// - Interface selected only when the interface strap is tied low.
// - Change line is open-drain, active low, low while messages pending.
// - Pointer top bit also requests a checksum byte on each message read.
`default_nettype none
module irap_target #(
  parameter logic [15:0] MSG_BASE = irap_pkg::MSG_BASE_DEF,
  parameter logic [15:0] MSG_SIZE = irap_pkg::MSG_SIZE_DEF,
  parameter logic [7:0] POLY = irap_pkg::CRC_POLY
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Straps
  input wire logic target_address_strap,
  input wire logic host_interface_strap,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output var logic sda_o,
  output var logic sda_oe,
  // Message pending
  input wire logic msg_pending,
  output var logic message_pending_line_o,
  output var logic message_pending_line_oe,
  // Object memory
  output var logic [15:0] mem_addr,
  output var logic [7:0] mem_wdata,
  output var logic mem_we,
  output var logic mem_re,
  input wire logic [7:0] mem_rdata,
  // Write status
  output var logic wr_done,
  output var logic crc_fail
);
  irap_pkg::irap_state_t state_reg;
  irap_pkg::irap_idx_t idx_reg;
  logic strap_taken_reg;
  logic addr_sel_reg;
  logic iface_en_reg;
  logic scl_f;
  logic sda_f;
  logic scl_q_reg;
  logic sda_q_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] lo_reg;
  logic [7:0] pend_reg;
  logic have_pend_reg;
  logic rw_reg;
  logic nack_reg;
  logic in_write_reg;
  logic crc_mode_reg;
  logic [15:0] ptr_reg;
  logic [15:0] start_reg;
  logic [7:0] crc_val;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic fall_full;
  logic addr_hit;
  logic addr_evt;
  logic wr_byte_evt;
  logic wr_end_evt;
  logic rd_nack_evt;
  logic commit;
  logic [7:0] commit_byte;
  logic [15:0] msg_last;
  logic [15:0] ptr_next;
  logic crc_slot;
  logic [7:0] load_byte;
  logic crc_clear;
  logic crc_feed;
  logic [7:0] crc_data;

  irap_sync #(.RST_VAL(1'h1)) u_scl_sync (
    .clk(clk),
    .srst(srst),
    .pin(scl_i),
    .level(scl_f)
  );

  irap_sync #(.RST_VAL(1'h1)) u_sda_sync (
    .clk(clk),
    .srst(srst),
    .pin(sda_i),
    .level(sda_f)
  );

  irap_crc8 #(.POLY(POLY)) u_crc (
    .clk(clk),
    .srst(srst),
    .clear(crc_clear),
    .feed(crc_feed),
    .data(crc_data),
    .crc(crc_val)
  );

  // Straps are static, so one capture after release is enough
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_taken_reg <= 1'h0;
      addr_sel_reg <= 1'h0;
      iface_en_reg <= 1'h0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'h1;
      addr_sel_reg <= target_address_strap;
      iface_en_reg <= ~host_interface_strap;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end else begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_q_reg;
  assign scl_fall = ~scl_f & scl_q_reg;
  assign start_det = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
  assign stop_det = scl_f & scl_q_reg & ~sda_q_reg & sda_f;
  assign fall_full = scl_fall && (bit_cnt_reg == irap_pkg::BITS_PER_BYTE);
  assign addr_hit = (shift_reg[7:1] == (addr_sel_reg ? irap_pkg::TARGET_ADDR_HIGH
                    : irap_pkg::TARGET_ADDR_LOW)) && iface_en_reg;
  assign addr_evt = (state_reg == irap_pkg::IRAP_ADDR) && fall_full && addr_hit;
  assign wr_byte_evt = (state_reg == irap_pkg::IRAP_WR_BYTE) && fall_full;
  // A repeated start also closes a write
  assign wr_end_evt = (stop_det || start_det) && in_write_reg;
  assign rd_nack_evt = (state_reg == irap_pkg::IRAP_RD_ACK) && scl_fall && nack_reg;
  // Checksum mode holds each byte back until the next proves it was data
  assign commit = wr_byte_evt && (idx_reg == irap_pkg::IRAP_IDX_DATA)
                  && (!crc_mode_reg || have_pend_reg);
  assign commit_byte = crc_mode_reg ? pend_reg : shift_reg;
  assign msg_last = crc_mode_reg ? (MSG_BASE + MSG_SIZE - irap_pkg::CRC_BYTE_COUNT)
                    : (MSG_BASE + MSG_SIZE - irap_pkg::CRC_BYTE_COUNT
                       - irap_pkg::CRC_BYTE_COUNT);
  assign ptr_next = (ptr_reg == msg_last) ? MSG_BASE : (ptr_reg + irap_pkg::PTR_STEP);
  assign crc_slot = crc_mode_reg && (ptr_reg == msg_last);
  assign load_byte = crc_slot ? crc_val : mem_rdata;
  assign crc_clear = addr_evt || ((state_reg == irap_pkg::IRAP_RD_LOAD)
                     && (ptr_reg == MSG_BASE));
  assign crc_feed = (wr_byte_evt && (idx_reg != irap_pkg::IRAP_IDX_DATA)) || commit
                    || ((state_reg == irap_pkg::IRAP_RD_LOAD) && !crc_slot);
  assign crc_data = (state_reg == irap_pkg::IRAP_RD_LOAD) ? mem_rdata
                    : (commit ? commit_byte : shift_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= irap_pkg::IRAP_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'h0;
      nack_reg <= 1'h0;
      in_write_reg <= 1'h0;
      sda_oe <= 1'h0;
    end else if (start_det && iface_en_reg) begin
      state_reg <= irap_pkg::IRAP_ADDR;
      bit_cnt_reg <= 4'h0;
      in_write_reg <= 1'h0;
      sda_oe <= 1'h0;
    end else if (stop_det || !iface_en_reg) begin
      state_reg <= irap_pkg::IRAP_IDLE;
      in_write_reg <= 1'h0;
      sda_oe <= 1'h0;
    end else begin
      case (state_reg)
        irap_pkg::IRAP_IDLE: begin
          sda_oe <= 1'h0;
        end
        irap_pkg::IRAP_ADDR, irap_pkg::IRAP_WR_BYTE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (fall_full) begin
            if (state_reg == irap_pkg::IRAP_WR_BYTE || addr_hit) begin
              sda_oe <= 1'h1;
              state_reg <= irap_pkg::IRAP_ACK;
              if (state_reg == irap_pkg::IRAP_ADDR) begin
                rw_reg <= shift_reg[irap_pkg::RW_BIT];
                in_write_reg <= ~shift_reg[irap_pkg::RW_BIT];
              end
            end else begin
              state_reg <= irap_pkg::IRAP_IDLE;
            end
          end
        end
        irap_pkg::IRAP_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'h0;
            bit_cnt_reg <= 4'h0;
            state_reg <= rw_reg ? irap_pkg::IRAP_RD_REQ : irap_pkg::IRAP_WR_BYTE;
          end
        end
        irap_pkg::IRAP_RD_REQ: state_reg <= irap_pkg::IRAP_RD_WAIT;
        irap_pkg::IRAP_RD_WAIT: state_reg <= irap_pkg::IRAP_RD_LOAD;
        irap_pkg::IRAP_RD_LOAD: begin
          tx_reg <= load_byte;
          sda_oe <= ~load_byte[7];
          bit_cnt_reg <= 4'h0;
          state_reg <= irap_pkg::IRAP_RD_BYTE;
        end
        irap_pkg::IRAP_RD_BYTE: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (fall_full) begin
            sda_oe <= 1'h0;
            state_reg <= irap_pkg::IRAP_RD_ACK;
          end else if (scl_fall) begin
            tx_reg <= {tx_reg[6:0], 1'h0};
            sda_oe <= ~tx_reg[6];
          end
        end
        irap_pkg::IRAP_RD_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_f;
          end
          if (scl_fall) begin
            state_reg <= nack_reg ? irap_pkg::IRAP_IDLE : irap_pkg::IRAP_RD_REQ;
          end
        end
        default: state_reg <= irap_pkg::IRAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idx_reg <= irap_pkg::IRAP_IDX_LOW;
      lo_reg <= 8'h00;
      pend_reg <= 8'h00;
      have_pend_reg <= 1'h0;
    end else if (addr_evt) begin
      idx_reg <= irap_pkg::IRAP_IDX_LOW;
      have_pend_reg <= 1'h0;
    end else if (wr_byte_evt) begin
      case (idx_reg)
        irap_pkg::IRAP_IDX_LOW: begin
          lo_reg <= shift_reg;
          idx_reg <= irap_pkg::IRAP_IDX_HIGH;
        end
        irap_pkg::IRAP_IDX_HIGH: idx_reg <= irap_pkg::IRAP_IDX_DATA;
        default: begin
          pend_reg <= shift_reg;
          have_pend_reg <= crc_mode_reg;
        end
      endcase
    end
  end

  // Pointer is never cleared by a transfer, only reloaded, advanced or restored
  always_ff @(posedge clk) begin
    if (srst) begin
      ptr_reg <= irap_pkg::PTR_RESET;
      start_reg <= irap_pkg::PTR_RESET;
      crc_mode_reg <= 1'h0;
    end else if (wr_end_evt) begin
      ptr_reg <= start_reg;
    end else if (rd_nack_evt) begin
      ptr_reg <= start_reg;
    end else if (addr_evt && shift_reg[irap_pkg::RW_BIT]) begin
      start_reg <= ptr_reg;
    end else if (wr_byte_evt && idx_reg == irap_pkg::IRAP_IDX_HIGH) begin
      ptr_reg <= {1'h0, shift_reg[6:0], lo_reg};
      start_reg <= {1'h0, shift_reg[6:0], lo_reg};
      crc_mode_reg <= shift_reg[irap_pkg::CRC_FLAG_BIT];
    end else if (commit) begin
      ptr_reg <= ptr_reg + irap_pkg::PTR_STEP;
    end else if (state_reg == irap_pkg::IRAP_RD_LOAD) begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_addr <= irap_pkg::PTR_RESET;
      mem_wdata <= 8'h00;
      mem_we <= 1'h0;
      mem_re <= 1'h0;
    end else begin
      mem_we <= commit;
      mem_re <= (state_reg == irap_pkg::IRAP_RD_REQ);
      if (commit || state_reg == irap_pkg::IRAP_RD_REQ) begin
        mem_addr <= ptr_reg;
      end
      if (commit) begin
        mem_wdata <= commit_byte;
      end
    end
  end

  // Mismatch is only reported; stored data stays
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_done <= 1'h0;
      crc_fail <= 1'h0;
    end else begin
      wr_done <= wr_end_evt;
      crc_fail <= wr_end_evt && crc_mode_reg
                  && (!have_pend_reg || pend_reg != crc_val);
    end
  end

  // Level follows the core so a level-triggered host never misses one
  always_ff @(posedge clk) begin
    if (srst) begin
      message_pending_line_oe <= 1'h0;
      message_pending_line_o <= 1'h0;
      sda_o <= 1'h0;
    end else begin
      message_pending_line_oe <= msg_pending && iface_en_reg;
      message_pending_line_o <= 1'h0;
      sda_o <= 1'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_addr_ack: assert property (addr_evt |=> sda_oe && state_reg == irap_pkg::IRAP_ACK)
    else $error("address match not acknowledged");
  chk_ptr_load: assert property (wr_byte_evt && idx_reg == irap_pkg::IRAP_IDX_HIGH
    |=> ptr_reg == {1'h0, $past(shift_reg[6:0]), $past(lo_reg)} && ptr_reg == start_reg)
    else $error("pointer load wrong");
  chk_write_incr: assert property (commit |=> mem_we && mem_addr == $past(ptr_reg)
    && ptr_reg == $past(ptr_reg) + irap_pkg::PTR_STEP)
    else $error("write address or increment wrong");
  chk_stop_restore: assert property (wr_end_evt |=> ptr_reg == $past(start_reg))
    else $error("pointer not restored after write");
  chk_crc_dropped: assert property (wr_end_evt && crc_mode_reg |=> !mem_we && wr_done)
    else $error("checksum byte stored as data");
  chk_nack_restore: assert property (rd_nack_evt |=> ptr_reg == $past(start_reg)
    ##1 state_reg == irap_pkg::IRAP_IDLE)
    else $error("pointer not restored on nack");
  chk_msg_rewind: assert property (state_reg == irap_pkg::IRAP_RD_LOAD && ptr_reg == msg_last
    |=> ptr_reg == MSG_BASE)
    else $error("message pointer not rewound");
  chk_chg_level: assert property (msg_pending && iface_en_reg ##1 msg_pending
    |-> message_pending_line_oe && !message_pending_line_o)
    else $error("change line not low while pending");
  chk_iface_off: assert property (!iface_en_reg |=> !sda_oe)
    else $error("bus driven with interface deselected");
endmodule
`default_nettype wire

// >>> testbench/irap_host.sv
`default_nettype none
module irap_host (
  // System
  input wire logic clk,
  // Wired data level
  input wire logic sda,
  // Pull-downs, released lines float high on the pull-ups
  output var logic scl_low,
  output var logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sample at end of high: target answers up to ~9 clk after a fall
  task automatic bit_io(input logic b, output logic r);
    cyc(6);
    sda_low = ~b;
    cyc(6);
    scl_low = 1'b0;
    cyc(12);
    r = sda;
    scl_low = 1'b1;
  endtask

  task automatic start_c();
    sda_low = 1'b1;
    cyc(12);
    scl_low = 1'b1;
  endtask

  task automatic stop_c();
    cyc(6);
    sda_low = 1'b1;
    cyc(6);
    scl_low = 1'b0;
    cyc(12);
    sda_low = 1'b0;
    cyc(20);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ irap_pkg::CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  task automatic write_txn(input logic [6:0] dev, input logic [15:0] ptr,
                           input logic [7:0] data[$], input logic crc_on,
                           input logic crc_bad, output logic acks);
    logic a;
    logic [7:0] c;
    logic [7:0] hi;
    hi = {crc_on, ptr[14:8]};
    c = crc_step(crc_step(irap_pkg::CRC_INIT, ptr[7:0]), hi);
    start_c();
    put_byte({dev, 1'b0}, acks);
    put_byte(ptr[7:0], a);
    acks &= a;
    put_byte(hi, a);
    acks &= a;
    foreach (data[i]) begin
      c = crc_step(c, data[i]);
      put_byte(data[i], a);
      acks &= a;
    end
    if (crc_on) begin
      put_byte(c ^ {7'h00, crc_bad}, a);
      acks &= a;
    end
    stop_c();
  endtask

  task automatic read_txn(input logic [6:0] dev, input int n, output logic [7:0] d[$],
                          output logic ack);
    logic [7:0] b;
    d = {};
    start_c();
    put_byte({dev, 1'b1}, ack);
    for (int i = 0; i < n; i++) begin
      get_byte(i == n - 1, b);
      d.push_back(b);
    end
    stop_c();
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MSZ = 16'h0004;
  localparam logic [15:0] MB = irap_pkg::MSG_BASE_DEF;
  logic clk, srst, as_strap, if_strap, sda_o, sda_oe, msg_pending, line_o, line_oe;
  logic mem_we, mem_re, wr_done, crc_fail, scl_low, sda_low, ack;
  wire logic scl, sda;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] mem [0:65535];
  logic [7:0] q[$];
  logic [7:0] r[$];
  int fails = 0, n_tests = 0, done_cnt = 0, fail_cnt = 0, d0, f0;

  assign scl = ~scl_low;
  assign sda = ~(sda_low | sda_oe);

  irap_target #(.MSG_SIZE(MSZ)) dut (
    .clk(clk), .srst(srst), .target_address_strap(as_strap),
    .host_interface_strap(if_strap), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .msg_pending(msg_pending), .message_pending_line_o(line_o),
    .message_pending_line_oe(line_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata), .wr_done(wr_done),
    .crc_fail(crc_fail)
  );

  irap_host host (.clk(clk), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // Idle read bus toggles so stale data never passes for fresh
  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    done_cnt <= done_cnt + int'(wr_done);
    fail_cnt <= fail_cnt + int'(crc_fail);
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic a, input logic i);
    srst = 1'b1;
    as_strap = a;
    if_strap = i;
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (20) @(posedge clk);
    #1;
  endtask

  task automatic t_write();
    q = {8'h96, 8'h9B, 8'hA0};
    d0 = done_cnt;
    f0 = fail_cnt;
    host.write_txn(7'h4C, 16'h1234, q, 1'b0, 1'b0, ack);
    check({7'h00, ack}, 8'h01);
    check(mem[16'h1234], 8'h96);
    check(mem[16'h1235], 8'h9B);
    check(mem[16'h1236], 8'hA0);
    check(8'(done_cnt - d0), 8'h01);
    check(8'(fail_cnt - f0), 8'h00);
  endtask

  task automatic t_read();
    host.read_txn(7'h4C, 4, r, ack);
    check({7'h00, ack}, 8'h01);
    check(r[0], 8'h96);
    check(r[3], pat(16'h1237));
    host.read_txn(7'h4C, 2, r, ack);
    check(r[0], 8'h96);
    check(r[1], 8'h9B);
    q = {};
    host.write_txn(7'h4C, 16'h2000, q, 1'b0, 1'b0, ack);
    host.read_txn(7'h4C, 2, r, ack);
    check(r[0], pat(16'h2000));
    check(r[1], pat(16'h2001));
  endtask

  task automatic t_crc();
    q = {8'h11, 8'h22};
    d0 = done_cnt;
    f0 = fail_cnt;
    host.write_txn(7'h4C, 16'h1300, q, 1'b1, 1'b0, ack);
    check(mem[16'h1300], 8'h11);
    check(mem[16'h9300], pat(16'h9300));
    check(mem[16'h1301], 8'h22);
    check(mem[16'h1302], pat(16'h1302));
    check(8'(fail_cnt - f0), 8'h00);
    q = {8'h33};
    host.write_txn(7'h4C, 16'h1310, q, 1'b1, 1'b1, ack);
    check(mem[16'h1310], 8'h33);
    check(mem[16'h1311], pat(16'h1311));
    check(8'(fail_cnt - f0), 8'h01);
    check(8'(done_cnt - d0), 8'h02);
  endtask

  task automatic t_rewind();
    q = {};
    host.write_txn(7'h4C, MB, q, 1'b0, 1'b0, ack);
    host.read_txn(7'h4C, 6, r, ack);
    for (int i = 0; i < 6; i++) begin
      check(r[i], pat(MB + 16'(i) % (MSZ - 16'h0001)));
    end
  endtask

  task automatic t_pending();
    msg_pending = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({6'h00, line_oe, line_o}, 8'h02);
    msg_pending = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, line_oe}, 8'h00);
    check({7'h00, sda_o}, 8'h00);
  endtask

  // Checksum read: last message slot carries the sum of the slots before it
  task automatic t_msg_crc();
    logic [7:0] c;
    q = {};
    c = host.crc_step(host.crc_step(host.crc_step(irap_pkg::CRC_INIT, pat(MB)),
        pat(MB + 16'h0001)), pat(MB + 16'h0002));
    host.write_txn(7'h4C, MB, q, 1'b1, 1'b0, ack);
    host.read_txn(7'h4C, 5, r, ack);
    check(r[0], pat(MB));
    check(r[2], pat(MB + 16'h0002));
    check(r[3], c);
    check(r[4], pat(MB));
  endtask

  task automatic t_straps();
    q = {};
    do_reset(1'b1, 1'b0);
    host.write_txn(7'h4C, 16'h0000, q, 1'b0, 1'b0, ack);
    check({7'h00, ack}, 8'h00);
    host.write_txn(7'h4D, 16'h0000, q, 1'b0, 1'b0, ack);
    check({7'h00, ack}, 8'h01);
    do_reset(1'b0, 1'b1);
    host.write_txn(7'h4C, 16'h0000, q, 1'b0, 1'b0, ack);
    check({7'h00, ack}, 8'h00);
  endtask

  initial begin
    msg_pending = 1'b0;
    // Known pattern everywhere so untouched locations can be checked
    for (int i = 0; i < 65536; i++) begin
      mem[i] = pat(16'(i));
    end
    do_reset(1'b0, 1'b0);
    t_write();
    t_read();
    t_crc();
    t_rewind();
    t_msg_crc();
    t_pending();
    t_straps();
    wrap_up();
  end

  // About 60 bytes at ~220 clk each; three times that bounds a hang
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
